//--- core/adcrc_pkg.sv
package adcrc_pkg;

  // Printed offsets are consecutive, not four apart, so they are register indices.
  localparam logic [15:0] IDX_CTRL_STATUS = 16'h0070;
  localparam logic [15:0] IDX_RESULT_HIGH = 16'h0071;
  localparam logic [15:0] IDX_RESULT_LOW  = 16'h0072;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'h0073;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'h0074;

  localparam int unsigned ADDR_W = 12;

  localparam int unsigned POS_DONE   = 7;
  localparam int unsigned POS_SPEED  = 6;
  localparam int unsigned POS_ON     = 5;
  localparam int unsigned POS_RSVD   = 4;
  localparam int unsigned RES_W      = 10;

  localparam logic [7:0] CSR_RESET    = 8'h00;
  localparam logic [7:0] CSR_WR_MASK  = 8'h6F;
  localparam logic [7:0] RES_RESET    = 8'h00;

  // Converter clock dividers: slow is pclk/4, fast is pclk/2.
  localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0] DIV_FAST_LAST = 2'h1;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_W    = 1;

  typedef struct packed {
    logic       speed;
    logic       on;
    logic [3:0] channel_select;
  } adcrc_cfg_t;

  typedef struct packed {
    logic             start;
    logic             convert_tick;
    logic [3:0]       channel_select;
  } adcrc_core_req_t;

  typedef enum logic [1:0] {
    ADCRC_IDLE,
    ADCRC_START,
    ADCRC_BUSY
  } adcrc_state_t;

endpackage

//--- core/adcrc_top.sv
`timescale 1ns/10ps
// Behaviour
// - High byte read or control write clears done
// - Control register writable except read-only done bit and bit four, which stays zero
// - Speed bit: 0 divides by four, 1 by two
// - On bit enables; clearing stops conversion
// - Channel field selects input n directly
// - High byte shows result bits nine to two
// - Low byte shows bits one, zero; rest zero
// - Registers at five consecutive word addresses
// - Converts continuously; sets done, updates result
// - Channel change restarts conversion, clears done
module adcrc_top (
  // APB clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [adcrc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Converter core
  output adcrc_pkg::adcrc_core_req_t      core_req,
  output logic                            core_enable,
  input  wire logic                       core_done,
  input  wire logic [adcrc_pkg::RES_W-1:0] core_result,
  // Interrupt
  output logic                            irq
);

  logic [7:0]                       csr_ff;
  logic [7:0]                       nxt_csr;
  logic [adcrc_pkg::RES_W-1:0]      result_ff;
  logic [adcrc_pkg::IRQ_W-1:0]      irq_status_ff;
  logic [adcrc_pkg::IRQ_W-1:0]      nxt_irq_status;
  logic [adcrc_pkg::IRQ_W-1:0]      irq_mask_ff;
  logic [1:0]                       div_ff;
  adcrc_pkg::adcrc_state_t          state_ff;
  adcrc_pkg::adcrc_state_t          nxt_state;
  adcrc_pkg::adcrc_cfg_t            cfg;
  logic [31:0]                      nxt_prdata;

  // Byte address to register index. An unaligned address matches no register.
  function automatic logic idx_hit(input logic [adcrc_pkg::ADDR_W-1:0] a,
                                   input logic [15:0]                  idx);
    idx_hit = (a[1:0] == 2'h0) && ({6'h00, a[adcrc_pkg::ADDR_W-1:2]} == idx);
  endfunction

  // The slave answers in the first access cycle, so pready is a registered
  // copy of the setup phase and every transfer takes exactly two cycles.
  wire setup_phase = psel && !penable;
  wire access      = psel && penable && pready;
  wire wr          = access && pwrite;
  wire rd          = access && !pwrite;

  wire hit_csr  = idx_hit(paddr, adcrc_pkg::IDX_CTRL_STATUS);
  wire hit_hi   = idx_hit(paddr, adcrc_pkg::IDX_RESULT_HIGH);
  wire hit_lo   = idx_hit(paddr, adcrc_pkg::IDX_RESULT_LOW);
  wire hit_ist  = idx_hit(paddr, adcrc_pkg::IDX_IRQ_STATUS);
  wire hit_imsk = idx_hit(paddr, adcrc_pkg::IDX_IRQ_MASK);
  wire hit_any  = hit_csr || hit_hi || hit_lo || hit_ist || hit_imsk;

  wire wr_csr   = wr && hit_csr;
  wire rd_hi    = rd && hit_hi;

  assign cfg.speed          = csr_ff[adcrc_pkg::POS_SPEED];
  assign cfg.on             = csr_ff[adcrc_pkg::POS_ON];
  assign cfg.channel_select = csr_ff[3:0];

  // Bit four is kept at zero in hardware, whatever software writes.
  wire [7:0] csr_wr_val = pwdata[7:0] & adcrc_pkg::CSR_WR_MASK;
  wire       new_on     = csr_wr_val[adcrc_pkg::POS_ON];
  wire       chan_chg   = wr_csr && (csr_wr_val[3:0] != cfg.channel_select);
  wire       on_rise    = wr_csr && new_on && !cfg.on;
  wire       turn_off   = wr_csr && !new_on;

  // Converter clock tick, one pclk pulse per converter clock period.
  wire [1:0] div_last = cfg.speed ? adcrc_pkg::DIV_FAST_LAST
                                  : adcrc_pkg::DIV_SLOW_LAST;
  wire       div_wrap = (div_ff >= div_last);
  wire [1:0] nxt_div  = (!cfg.on || div_wrap) ? 2'h0 : div_ff + 2'h1;

  // A done strobe only counts while busy and not being disabled or redirected.
  wire done_ok = core_done && (state_ff == adcrc_pkg::ADCRC_BUSY) && cfg.on
                 && !turn_off && !chan_chg;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adcrc_pkg::ADCRC_IDLE: begin
        if (on_rise) begin
          nxt_state = adcrc_pkg::ADCRC_START;
        end
      end
      adcrc_pkg::ADCRC_START: begin
        nxt_state = adcrc_pkg::ADCRC_BUSY;
      end
      adcrc_pkg::ADCRC_BUSY: begin
        if (chan_chg || done_ok) begin
          nxt_state = adcrc_pkg::ADCRC_START;
        end
      end
      default: begin
        nxt_state = adcrc_pkg::ADCRC_IDLE;
      end
    endcase
    if (turn_off) begin
      nxt_state = adcrc_pkg::ADCRC_IDLE;
    end
  end

  // Done flag: a completing conversion wins over a clearing access in the same
  // cycle, except when that access disables or redirects the converter.
  always_comb begin
    nxt_csr = csr_ff;
    if (wr_csr) begin
      nxt_csr = csr_wr_val;
    end else if (rd_hi) begin
      nxt_csr[adcrc_pkg::POS_DONE] = 1'b0;
    end
    if (done_ok) begin
      nxt_csr[adcrc_pkg::POS_DONE] = 1'b1;
    end
  end

  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (wr && hit_ist) begin
      nxt_irq_status = irq_status_ff & ~pwdata[adcrc_pkg::IRQ_W-1:0];
    end
    if (done_ok) begin
      nxt_irq_status[adcrc_pkg::IRQ_DONE] = 1'b1;
    end
  end

  // Result bits sit unlatched, so a read pair can straddle a completion.
  wire [7:0] result_high = result_ff[9:2];
  wire [7:0] result_low  = {6'h00, result_ff[1:0]};

  // Read words of each register, zero above the bits that the register holds.
  wire [31:0] word_csr  = {24'h000000, csr_ff};
  wire [31:0] word_hi   = {24'h000000, result_high};
  wire [31:0] word_lo   = {24'h000000, result_low};
  wire [31:0] word_ist  = {31'h00000000, irq_status_ff};
  wire [31:0] word_imsk = {31'h00000000, irq_mask_ff};

  assign nxt_prdata = hit_csr  ? word_csr :
                      hit_hi   ? word_hi :
                      hit_lo   ? word_lo :
                      hit_ist  ? word_ist :
                      hit_imsk ? word_imsk : 32'h00000000;

  // Next values for the registers that the blocks below only load. Keeping the
  // choice in named wires leaves each flip-flop block a plain reset or load.
  wire [adcrc_pkg::RES_W-1:0] nxt_result   = done_ok ? core_result : result_ff;
  wire [adcrc_pkg::IRQ_W-1:0] nxt_irq_mask = (wr && hit_imsk) ? pwdata[adcrc_pkg::IRQ_W-1:0]
                                                              : irq_mask_ff;

  // Read data is chosen during the setup phase, so it already stands when pready
  // rises. Outside a read answer the data bus is held at zero.
  wire        nxt_pready  = setup_phase;
  wire [31:0] nxt_rd_word = (setup_phase && !pwrite) ? nxt_prdata : 32'h00000000;
  wire        nxt_pslverr = setup_phase && !hit_any;

  // Converter requests are built from next-state values, so a start pulse and the
  // channel that it applies to reach the core in the same cycle.
  wire        nxt_start   = (nxt_state == adcrc_pkg::ADCRC_START);
  wire        nxt_on      = nxt_csr[adcrc_pkg::POS_ON];
  wire        nxt_tick    = nxt_on && (nxt_div == 2'h0);
  wire [3:0]  nxt_channel = nxt_csr[3:0];

  // The interrupt follows the status as it will be, one cycle after the event.
  wire        nxt_irq     = |(nxt_irq_status & irq_mask_ff);

  // Control and status register. The done flag inside it is owned by hardware and
  // only the masked write value reaches the other bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_ff <= adcrc_pkg::CSR_RESET;
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  // Result bits. They load only on an accepted done strobe, so a disable or a
  // channel change in the same cycle leaves the previous result standing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= {adcrc_pkg::RES_W{1'b0}};
    end else begin
      result_ff <= nxt_result;
    end
  end

  // Sequencer state. Reset puts it in idle, and only a fresh rise of the on bit
  // leaves idle again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= adcrc_pkg::ADCRC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Converter clock divider. It is held at zero while the converter is off, so
  // the first tick after enabling comes at a fixed point. A speed change takes
  // effect at once on the running count, which may shorten one converter clock period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // Interrupt status, set by events and cleared by writing ones. A set in the
  // same cycle as its clear wins, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // Interrupt mask. A one lets the matching status bit reach the interrupt pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= '0;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Bus handshake. Every transfer is answered in its first access cycle, so no
  // wait state is ever inserted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= nxt_pready;
    end
  end

  // Read data. It stands for the one cycle in which pready is high and is zero
  // for writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= nxt_rd_word;
    end
  end

  // Error response for addresses that hold no register. Writes to them are lost
  // and reads return zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= nxt_pslverr;
    end
  end

  // Requests to the converter core. A start pulse lasts one cycle and the tick
  // runs only while the converter is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= '0;
    end else begin
      core_req.start          <= nxt_start;
      core_req.convert_tick   <= nxt_tick;
      core_req.channel_select <= nxt_channel;
    end
  end

  // Converter power enable. It copies the on bit so that the analog part is
  // powered down in the same cycle as the sequencer returns to idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_enable <= 1'b0;
    end else begin
      core_enable <= nxt_on;
    end
  end

  // Level interrupt. It stays high while an unmasked status bit is set, until
  // software clears that bit or masks it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= nxt_irq;
    end
  end

endmodule

//--- verif/adcrc_props.sv
`timescale 1ns/10ps
module adcrc_props (
  // Bus and converter pins
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire adcrc_pkg::adcrc_core_req_t core_req,
  input wire logic                       core_enable,
  input wire logic                       core_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rdc = pready && !pwrite;
  wire wc  = psel && penable && pready && pwrite && paddr == 12'h1C0;
  answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer late or long");
  mapped_a: assert property (pready && paddr inside {12'h1C0, 12'h1C4, 12'h1C8} |-> !pslverr)
    else $error("mapped register refused");
  lowzero_a: assert property (rdc && paddr == 12'h1C8 |-> prdata[31:2] == 30'h0)
    else $error("low byte upper bits set");
  csr_read_a: assert property (rdc && paddr == 12'h1C0 |-> prdata[31:8] == 24'h0 && !prdata[4])
    else $error("control readback wrong");
  chan_out_a: assert property (wc ##2 1 |-> core_req.channel_select == $past(pwdata[3:0], 2))
    else $error("channel not passed on");
  on_level_a: assert property (wc ##2 1 |-> core_enable == $past(pwdata[5], 2))
    else $error("enable does not follow");
  start_a: assert property (wc && pwdata[5] && !core_enable |-> ##[1:3] core_req.start)
    else $error("no start after enable");
  quiet_off_a: assert property (!core_enable && !$past(core_enable) |-> !core_req.start && !core_req.convert_tick)
    else $error("activity while off");
  tick_gap_a: assert property (core_req.convert_tick |=> !core_req.convert_tick)
    else $error("converter clock too fast");
  cover property (core_done);
  cover property (wc && !pwdata[5]);
  cover property (pslverr);
endmodule

//--- verif/adcrc_core_model.sv
`timescale 1ns/10ps
module adcrc_core_model (
  // Clock, reset and converter pins
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire adcrc_pkg::adcrc_core_req_t core_req,
  input  wire logic                       core_enable,
  output logic                            core_done,
  output logic [9:0]                      core_result
);
  logic [3:0] cnt_ff;
  logic       busy_ff;
  wire  [9:0] val = {core_req.channel_select, 6'h25};
  // Outside the done pulse the result is inverted so stale data never looks valid.
  assign core_result = core_done ? val : ~val;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff   <= 1'b0;
      cnt_ff    <= 4'h0;
      core_done <= 1'b0;
    end else begin
      core_done <= busy_ff && core_req.convert_tick && cnt_ff == 4'h9;
      if (core_req.start || !core_enable) begin
        busy_ff <= core_req.start && core_enable;
        cnt_ff  <= 4'h0;
      end else if (busy_ff && core_req.convert_tick) begin
        busy_ff <= cnt_ff != 4'h9;
        cnt_ff  <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

//--- verif/adcrc_top_tb.sv
`timescale 1ns/10ps
module adcrc_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        core_enable, core_done, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  core_result;
  logic [7:0]  cs;
  int          fails, checks_done, cyc, n;
  adcrc_pkg::adcrc_core_req_t core_req;
  adcrc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_req, .core_enable, .core_done, .core_result, .irq);
  adcrc_core_model core (.pclk, .presetn, .core_req, .core_enable, .core_done, .core_result);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 5; n++) rc(12'h1C0 + 12'(4 * n), 32'h0);
    apb(1'b1, 12'h1C0, 32'hFFFF_FF5F);
    rc(12'h1C0, 32'h4F);
    apb(1'b1, 12'h1C4, 32'hFF);
    rc(12'h1C4, 32'h0);
    rc(12'h1C1, 32'h0);
    chk(err, 32'h1);
    rc(12'h1D4, 32'h0);
    chk(err, 32'h1);
    for (int c = 0; c < 16; c++) begin
      cs = {1'b0, c[0], 2'h2, c[3:0]};
      apb(1'b1, 12'h1C0, {24'h0, cs});
      rc(12'h1C0, {24'h0, cs});
      n = 0;
      repeat (40) @(posedge pclk) n += core_req.convert_tick;
      chk(n, c[0] ? 20 : 10);
      // Clear the flag first so the poll catches a fresh result with time left to read.
      apb(1'b1, 12'h1C0, {24'h0, cs});
      do apb(1'b0, 12'h1C0, 32'h0); while (rd[7] !== 1'b1);
      chk(rd, {24'h0, cs | 8'h80});
      rc(12'h1C8, 32'h1);
      rc(12'h1C4, {24'h0, c[3:0], 4'h9});
      rc(12'h1C0, {24'h0, cs});
    end
    rc(12'h1CC, 32'h1);
    chk(irq, 32'h0);
    apb(1'b1, 12'h1D0, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'b1, 12'h1C0, 32'h25);
    repeat (10) @(posedge pclk);
    apb(1'b1, 12'h1C0, 32'h0);
    apb(1'b1, 12'h1CC, 32'h1);
    repeat (80) @(posedge pclk);
    rc(12'h1C0, 32'h0);
    rc(12'h1CC, 32'h0);
    chk(irq, 32'h0);
    conclude();
  end
endmodule
bind adcrc_top adcrc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .core_req, .core_enable, .core_done);
